// ===== inc/lowv_pkg.sv
// Constants and types for the low-voltage detect and reset block
package lowv_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam int ADDR_W = 8;
	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] IDX_IST = 8'h01;
	localparam logic [ADDR_W-1:0] IDX_IMSK = 8'h02;
	localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h06;
	localparam logic [ADDR_W-1:0] ADDR_CFG = IDX_CFG << 2;
	localparam logic [ADDR_W-1:0] ADDR_IST = IDX_IST << 2;
	localparam logic [ADDR_W-1:0] ADDR_IMSK = IDX_IMSK << 2;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = IDX_CTRL << 2;

	// ********************************
	// Control register fields
	// ********************************
	localparam int B_LVL_LO = 0;
	localparam int B_LVL_HI = 1;
	localparam int B_DET_EN = 2;
	localparam int B_WAKE_EN = 3;
	localparam int B_IRQ_EN = 4;
	localparam int B_STATE_N = 5;
	localparam int B_FLAG = 6;
	localparam logic [1:0] LVL_RST = 2'h0;

	// ********************************
	// Reset-level config and interrupt status
	// ********************************
	localparam logic [1:0] RLVL_POR_ONLY = 2'h3;
	localparam int IRQ_W = 3;
	localparam int IS_DET = 0;
	localparam int IS_HALT = 1;
	localparam int IS_RST = 2;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	// ********************************
	// Bus answers and timing
	// ********************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_NS = 8;
	localparam int BO_TIME_US = 80;
	localparam int BO_CYC = (BO_TIME_US * 1000) / CLK_NS;

	typedef enum logic [2:0] {
		BO_IDLE = 3'b001,
		BO_HALT = 3'b010,
		BO_RESET = 3'b100
	} bo_state_t;

endpackage

// ===== src/low_voltage_detect_reset.sv
// Low-voltage detector control, brown-out halt/reset and register slave
`timescale 1ns/1ns

module low_voltage_detect_reset #(
	parameter int BO_CYCLES = lowv_pkg::BO_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [lowv_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [lowv_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic lowv_cmp_n,
	input wire logic brownout_cmp,
	input wire logic sleep_instr,
	input wire logic global_irq_on_instr,
	input wire logic global_irq_off_instr,
	output logic lowv_level_sel_hi,
	output logic lowv_level_sel_lo,
	output logic lowv_detect_en,
	output logic reset_level_sel_hi,
	output logic reset_level_sel_lo,
	output logic brownout_mon_en,
	output logic core_wake,
	output logic core_halt,
	output logic sys_reset_req,
	output logic irq_vector_req,
	output logic irq
);

	// ********************************
	// Declarations
	// ********************************
	localparam int CNT_W = $clog2(BO_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BO_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic [1:0] cmp_meta_r, cmp_sync_r, cmp_async, level_sel_r, reset_sel_r;
	logic det_en_r, wake_en_r, irq_en_r, flag_r, det_low_d_r, global_en_r, sleep_r;
	logic [lowv_pkg::IRQ_W-1:0] ist_r, imsk_r, ev;
	lowv_pkg::bo_state_t bo_r, bo_nxt;
	logic [CNT_W-1:0] bo_cnt_r;
	logic bvalid_r, rvalid_r, rd_hit, wr_go, rd_go, wr_lane0;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, rd_val;
	logic det_low, det_event, bo_active, bo_enter_rst, bo_enter_halt, state_n;
	logic [7:0] ctrl_val;

	// ********************************
	// Comparator synchronisers
	// ********************************
	// Bit 0 detector comparator, bit 1 brown-out comparator
	assign cmp_async = {brownout_cmp, lowv_cmp_n};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			// Two-stage crossing of an asynchronous comparator
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cmp_meta_r[gi] <= (gi == 0);
					cmp_sync_r[gi] <= (gi == 0);
				end else if (ce) begin
					cmp_meta_r[gi] <= cmp_async[gi];
					cmp_sync_r[gi] <= cmp_meta_r[gi];
				end
			end
		end
	endgenerate

	// ********************************
	// Detector state and events
	// ********************************
	// Low voltage only counts while detection is on
	assign det_low = det_en_r & ~cmp_sync_r[0];
	assign state_n = ~det_low;
	assign det_event = det_low & ~det_low_d_r;
	assign bo_active = cmp_sync_r[1] &
		(reset_sel_r != lowv_pkg::RLVL_POR_ONLY);
	assign bo_enter_halt = (bo_r == lowv_pkg::BO_IDLE) & bo_active;
	assign bo_enter_rst = (bo_r == lowv_pkg::BO_HALT) & bo_active &
		(bo_cnt_r == CNT_LAST);

	// Previous detector level for edge finding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			det_low_d_r <= 1'b0;
		end else if (ce) begin
			det_low_d_r <= det_low;
		end
	end

	// ********************************
	// Bus handshakes
	// ********************************
	// Write taken only with address and data both present
	assign awready = ce & awvalid & wvalid & ~bvalid_r;
	assign wready = awready;
	assign wr_go = awready;
	assign wr_lane0 = wr_go & wstrb[0];
	assign arready = ce & ~rvalid_r;
	assign rd_go = arready & arvalid;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= lowv_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				bvalid_r <= 1'b1;
				if (awaddr == lowv_pkg::ADDR_CFG || awaddr == lowv_pkg::ADDR_IST ||
					awaddr == lowv_pkg::ADDR_IMSK || awaddr == lowv_pkg::ADDR_CTRL) begin
					bresp_r <= lowv_pkg::RESP_OKAY;
				end else begin
					bresp_r <= lowv_pkg::RESP_SLVERR;
				end
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ********************************
	// Read mux
	// ********************************
	assign ctrl_val = {1'b0, flag_r, state_n, irq_en_r, wake_en_r,
		det_en_r, level_sel_r};

	// Address decode for reads
	always_comb begin
		rd_val = 32'h0;
		rd_hit = 1'b1;
		if (araddr == lowv_pkg::ADDR_CTRL) begin
			rd_val[7:0] = ctrl_val;
		end else if (araddr == lowv_pkg::ADDR_CFG) begin
			rd_val[1:0] = reset_sel_r;
		end else if (araddr == lowv_pkg::ADDR_IST) begin
			rd_val[lowv_pkg::IRQ_W-1:0] = ist_r;
		end else if (araddr == lowv_pkg::ADDR_IMSK) begin
			rd_val[lowv_pkg::IRQ_W-1:0] = imsk_r;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Read data and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r <= lowv_pkg::RESP_OKAY;
			rdata_r <= 32'h0;
		end else if (ce) begin
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rdata_r <= rd_val;
				rresp_r <= rd_hit ? lowv_pkg::RESP_OKAY : lowv_pkg::RESP_SLVERR;
			end else if (rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ********************************
	// Control and config registers
	// ********************************
	// Level, enables; software order is level, wake, irq, then enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_sel_r <= lowv_pkg::LVL_RST;
			det_en_r <= 1'b0;
			wake_en_r <= 1'b0;
			irq_en_r <= 1'b0;
			reset_sel_r <= lowv_pkg::RLVL_POR_ONLY;
		end else if (ce) begin
			if (wr_lane0 && awaddr == lowv_pkg::ADDR_CTRL) begin
				level_sel_r <= wdata[lowv_pkg::B_LVL_HI:lowv_pkg::B_LVL_LO];
				det_en_r <= wdata[lowv_pkg::B_DET_EN];
				wake_en_r <= wdata[lowv_pkg::B_WAKE_EN];
				irq_en_r <= wdata[lowv_pkg::B_IRQ_EN];
			end else if (wr_lane0 && awaddr == lowv_pkg::ADDR_CFG) begin
				reset_sel_r <= wdata[1:0];
			end
		end
	end

	// Sticky flag: reset clears, detection sets, software writes zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 1'b0;
		end else if (ce) begin
			if (bo_enter_rst) begin
				flag_r <= 1'b0;
			end else if (det_event) begin
				flag_r <= 1'b1;
			end else if (wr_lane0 && awaddr == lowv_pkg::ADDR_CTRL &&
				!wdata[lowv_pkg::B_FLAG]) begin
				flag_r <= 1'b0;
			end
		end
	end

	// ********************************
	// Global interrupt enable and sleep
	// ********************************
	// Off instruction wins if both arrive together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_en_r <= 1'b0;
		end else if (ce) begin
			if (global_irq_off_instr) begin
				global_en_r <= 1'b0;
			end else if (global_irq_on_instr) begin
				global_en_r <= 1'b1;
			end
		end
	end

	// Sleep held until wake or brown-out reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_r <= 1'b0;
		end else if (ce) begin
			if (core_wake || bo_enter_rst) begin
				sleep_r <= 1'b0;
			end else if (sleep_instr) begin
				sleep_r <= 1'b1;
			end
		end
	end

	// Raw comparator wakes even with the core clock slowed
	assign core_wake = sleep_r & wake_en_r & det_en_r & ~lowv_cmp_n;

	// ********************************
	// Brown-out sequencer
	// ********************************
	// Next state of the brown-out watcher
	always_comb begin
		bo_nxt = bo_r;
		case (bo_r)
			lowv_pkg::BO_IDLE: begin
				if (bo_active) begin
					bo_nxt = lowv_pkg::BO_HALT;
				end
			end
			lowv_pkg::BO_HALT: begin
				if (!bo_active) begin
					bo_nxt = lowv_pkg::BO_IDLE;
				end else if (bo_cnt_r == CNT_LAST) begin
					bo_nxt = lowv_pkg::BO_RESET;
				end
			end
			lowv_pkg::BO_RESET: begin
				if (!bo_active) begin
					bo_nxt = lowv_pkg::BO_IDLE;
				end
			end
			default: begin
				bo_nxt = lowv_pkg::BO_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bo_r <= lowv_pkg::BO_IDLE;
		end else if (ce) begin
			bo_r <= bo_nxt;
		end
	end

	// Time spent below the reset threshold
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bo_cnt_r <= '0;
		end else if (ce) begin
			if (bo_r == lowv_pkg::BO_HALT && bo_active) begin
				bo_cnt_r <= bo_cnt_r + CNT_ONE;
			end else begin
				bo_cnt_r <= '0;
			end
		end
	end

	// Halt keeps registers; reset request lasts until supply returns
	assign core_halt = (bo_r != lowv_pkg::BO_IDLE);
	assign sys_reset_req = (bo_r == lowv_pkg::BO_RESET);

	// ********************************
	// Interrupt status and mask
	// ********************************
	assign ev[lowv_pkg::IS_DET] = det_event;
	assign ev[lowv_pkg::IS_HALT] = bo_enter_halt;
	assign ev[lowv_pkg::IS_RST] = bo_enter_rst;

	// Sticky status, write one to clear, new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ist_r <= lowv_pkg::IRQ_RST;
			imsk_r <= lowv_pkg::IRQ_RST;
		end else if (ce) begin
			if (wr_lane0 && awaddr == lowv_pkg::ADDR_IST) begin
				ist_r <= (ist_r & ~wdata[lowv_pkg::IRQ_W-1:0]) | ev;
			end else begin
				ist_r <= ist_r | ev;
			end
			if (wr_lane0 && awaddr == lowv_pkg::ADDR_IMSK) begin
				imsk_r <= wdata[lowv_pkg::IRQ_W-1:0];
			end
		end
	end

	assign irq = |(ist_r & imsk_r);

	// ********************************
	// Core-facing outputs
	// ********************************
	// Vector request for the core's interrupt logic
	assign irq_vector_req = flag_r & irq_en_r & global_en_r;
	assign lowv_level_sel_hi = level_sel_r[1];
	assign lowv_level_sel_lo = level_sel_r[0];
	assign lowv_detect_en = det_en_r;
	assign reset_level_sel_hi = reset_sel_r[1];
	assign reset_level_sel_lo = reset_sel_r[0];
	assign brownout_mon_en = (reset_sel_r != lowv_pkg::RLVL_POR_ONLY);

endmodule

// ===== test/lowv_monitor.sv
// Port checker for the low-voltage detect and reset block
`timescale 1ns/1ns
module lowv_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic wvalid,
	input wire logic awready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic lowv_cmp_n,
	input wire logic brownout_cmp,
	input wire logic global_irq_off_instr,
	input wire logic lowv_detect_en,
	input wire logic core_wake,
	input wire logic core_halt,
	input wire logic sys_reset_req,
	input wire logic irq_vector_req
);
	// ********************************
	// Assertions
	// ********************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_b_hold; bvalid && !bready |=> bvalid; endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold; rvalid && !rready |=> rvalid; endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_aw; awready |-> awvalid && wvalid && !bvalid; endproperty
	a_aw: assert property (p_aw) else $error("write taken without both halves");
	property p_wake; core_wake |-> lowv_detect_en && !lowv_cmp_n; endproperty
	a_wake: assert property (p_wake) else $error("wake without detection");
	property p_off; global_irq_off_instr |=> !irq_vector_req; endproperty
	a_off: assert property (p_off) else $error("vector after global off");
	property p_rst_halt; sys_reset_req |-> core_halt; endproperty
	a_rst_halt: assert property (p_rst_halt) else $error("reset outside brown-out");
	property p_rst_after; $rose(sys_reset_req) |-> $past(core_halt, 2); endproperty
	a_rst_after: assert property (p_rst_after) else $error("reset without halt first");
	property p_release; !brownout_cmp [*4] |-> !core_halt; endproperty
	a_release: assert property (p_release) else $error("halt held after supply back");
	// Main scenarios
	c_wake: cover property (core_wake);
	c_rst: cover property (sys_reset_req);
	c_vec: cover property (irq_vector_req);
endmodule

// ===== test/tb_low_voltage_detect_reset.sv
// Testbench for the low-voltage detect and reset block
`timescale 1ns/1ns
module tb_low_voltage_detect_reset;
	localparam int BO = 20;
	localparam logic [7:0] AF = lowv_pkg::ADDR_CFG;
	localparam logic [7:0] AI = lowv_pkg::ADDR_IST;
	localparam logic [7:0] AM = lowv_pkg::ADDR_IMSK;
	localparam logic [7:0] AC = lowv_pkg::ADDR_CTRL;
	logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, rr, rb;
	logic lowv_cmp_n = 1'h1, brownout_cmp = 1'h0, sleep_instr = 1'h0;
	logic global_irq_on_instr = 1'h0, global_irq_off_instr = 1'h0;
	logic lowv_level_sel_hi, lowv_level_sel_lo, lowv_detect_en, reset_level_sel_hi;
	logic reset_level_sel_lo, brownout_mon_en, core_wake, core_halt, sys_reset_req;
	logic irq_vector_req, irq;
	int n_fail = 0, checked = 0, cnt;
	low_voltage_detect_reset #(
		.BO_CYCLES(BO)
	) dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.lowv_cmp_n(lowv_cmp_n),
		.brownout_cmp(brownout_cmp),
		.sleep_instr(sleep_instr),
		.global_irq_on_instr(global_irq_on_instr),
		.global_irq_off_instr(global_irq_off_instr),
		.lowv_level_sel_hi(lowv_level_sel_hi),
		.lowv_level_sel_lo(lowv_level_sel_lo),
		.lowv_detect_en(lowv_detect_en),
		.reset_level_sel_hi(reset_level_sel_hi),
		.reset_level_sel_lo(reset_level_sel_lo),
		.brownout_mon_en(brownout_mon_en),
		.core_wake(core_wake),
		.core_halt(core_halt),
		.sys_reset_req(sys_reset_req),
		.irq_vector_req(irq_vector_req),
		.irq(irq)
	);
	// Clock
	initial forever #4 aclk = ~aclk;
	// ********************************
	// Tasks
	// ********************************
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", s, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Each channel released at its own ready
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		rb = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	task rc(input string s, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(s, rv, e);
	endtask
	task cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task finish_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		n_fail++;
		finish_test;
	end
	// ********************************
	// Tests
	// ********************************
	initial begin
		cyc(3);
		aresetn <= 1'b1;
		rc("cfg", AF, 32'h3);
		rc("ctrl", AC, 32'h20);
		rc("ist", AI, 32'h0);
		rc("mask", AM, 32'h0);
		rc("unmapped", 8'h40, 32'h0);
		chk("unmapped resp", rr, 2'h2);
		wr(8'h40, 32'h0);
		chk("unmapped wr resp", rb, 2'h2);
		for (int i = 0; i < 4; i++) begin
			wr(AC, 32'(i));
			chk("lvl", {lowv_level_sel_hi, lowv_level_sel_lo}, 32'(i));
			wr(AF, 32'(i));
			chk("rlvl", {reset_level_sel_hi, reset_level_sel_lo, brownout_mon_en},
				{i[1:0], i != 3});
		end
		chk("wr resp", rb, 2'h0);
		$display("test registers done");
		brownout_cmp <= 1'b1;
		cyc(10);
		chk("halt por", core_halt, 1'b0);
		brownout_cmp <= 1'b0;
		lowv_cmp_n <= 1'b0;
		wr(AC, 32'h01);
		cyc(5);
		rc("ctrl off", AC, 32'h21);
		lowv_cmp_n <= 1'b1;
		wr(AM, 32'h1);
		global_irq_on_instr <= 1'b1;
		cyc(1);
		global_irq_on_instr <= 1'b0;
		wr(AC, 32'h1d);
		chk("det en", lowv_detect_en, 1'b1);
		cyc(5);
		rc("ctrl idle", AC, 32'h3d);
		chk("irq idle", irq, 1'b0);
		lowv_cmp_n <= 1'b0;
		cyc(3);
		chk("sync lag", irq, 1'b0);
		cyc(1);
		chk("sync out", irq, 1'b1);
		cyc(1);
		rc("ctrl det", AC, 32'h5d);
		chk("vec", irq_vector_req, 1'b1);
		chk("irq", irq, 1'b1);
		rc("ist", AI, 32'h1);
		lowv_cmp_n <= 1'b1;
		cyc(2);
		wr(AI, 32'h1);
		chk("irq clr", irq, 1'b0);
		rc("sticky", AC, 32'h7d);
		global_irq_off_instr <= 1'b1;
		cyc(1);
		global_irq_off_instr <= 1'b0;
		cyc(1);
		chk("vec off", irq_vector_req, 1'b0);
		// Enable low swallows the on pulse
		ce <= 1'b0;
		global_irq_on_instr <= 1'b1;
		cyc(1);
		global_irq_on_instr <= 1'b0;
		ce <= 1'b1;
		cyc(1);
		chk("vec frozen", irq_vector_req, 1'b0);
		global_irq_on_instr <= 1'b1;
		cyc(1);
		global_irq_on_instr <= 1'b0;
		cyc(1);
		chk("vec on", irq_vector_req, 1'b1);
		wr(AC, 32'h4d);
		chk("vec ie", irq_vector_req, 1'b0);
		rc("kept", AC, 32'h6d);
		wr(AC, 32'h1d);
		rc("flag clr", AC, 32'h3d);
		$display("test detect done");
		sleep_instr <= 1'b1;
		cyc(1);
		sleep_instr <= 1'b0;
		wr(AC, 32'h15);
		lowv_cmp_n <= 1'b0;
		cyc(3);
		chk("no wake", core_wake, 1'b0);
		lowv_cmp_n <= 1'b1;
		wr(AC, 32'h1d);
		cyc(3);
		lowv_cmp_n <= 1'b0;
		#1;
		chk("wake", core_wake, 1'b1);
		@(posedge aclk);
		cyc(5);
		rc("wake flag", AC, 32'h5d);
		$display("test sleep done");
		wr(AF, 32'h2);
		brownout_cmp <= 1'b1;
		cyc(10);
		chk("halt", core_halt, 1'b1);
		chk("no rst", sys_reset_req, 1'b0);
		brownout_cmp <= 1'b0;
		cyc(5);
		chk("halt end", core_halt, 1'b0);
		rc("held", AC, 32'h5d);
		brownout_cmp <= 1'b1;
		do @(posedge aclk); while (core_halt !== 1'b1);
		cnt = 0;
		while (core_halt === 1'b1 && sys_reset_req !== 1'b1) begin
			@(posedge aclk);
			cnt++;
		end
		chk("halt len", cnt >= BO && cnt <= BO + 1, 1'b1);
		chk("rst", sys_reset_req, 1'b1);
		brownout_cmp <= 1'b0;
		lowv_cmp_n <= 1'b1;
		cyc(5);
		rc("rst flag", AC, 32'h3d);
		rc("ist bo", AI, 32'h7);
		wr(AM, 32'h0);
		chk("irq masked", irq, 1'b0);
		wr(AM, 32'h7);
		chk("irq unmasked", irq, 1'b1);
		wr(AI, 32'h7);
		chk("irq cleared", irq, 1'b0);
		$display("test brown-out done");
		lowv_cmp_n <= 1'b0;
		cyc(5);
		rc("flag pre", AC, 32'h5d);
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		rc("flag rst", AC, 32'h20);
		rc("cfg rst", AF, 32'h3);
		lowv_cmp_n <= 1'b1;
		$display("test reset done");
		finish_test;
	end
endmodule
bind low_voltage_detect_reset lowv_monitor u_mon (
	.aclk(aclk),
	.aresetn(aresetn),
	.awvalid(awvalid),
	.wvalid(wvalid),
	.awready(awready),
	.bvalid(bvalid),
	.bready(bready),
	.rvalid(rvalid),
	.rready(rready),
	.lowv_cmp_n(lowv_cmp_n),
	.brownout_cmp(brownout_cmp),
	.global_irq_off_instr(global_irq_off_instr),
	.lowv_detect_en(lowv_detect_en),
	.core_wake(core_wake),
	.core_halt(core_halt),
	.sys_reset_req(sys_reset_req),
	.irq_vector_req(irq_vector_req)
);
